// file: dv/fifo_occupancy_model.sv
// Behavioural results FIFO occupancy that feeds the fill level to the register block.
// Assumes push and flush arrive on the core clock; depth is 32 entries.
`timescale 1ns/1ns
`default_nettype none

module fifo_occupancy_model
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Traffic from the bench and the register block
  input wire logic push_in,
  input wire logic flush_in,
  output logic [5:0] level_out
);
  logic [5:0] next_level;

  // Flush beats push; saturating at the depth mimics stop-on-full
  always_comb
  begin
    next_level = level_out;
    if (flush_in)
      next_level = 6'h00;
    else if (push_in && (level_out < 6'h20))
      next_level = level_out + 6'h01;
  end

  // Occupancy register
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      level_out <= 6'h00;
    else
      level_out <= next_level;
  end
endmodule : fifo_occupancy_model

`default_nettype wire

// file: dv/sensor_fifo_status_reset_regs_tb_top.sv
// Self-checking bench for the FIFO status, reset control, identity and coefficient registers.
// Assumes short soft reset counts; the flag refresh period stays at its real 2500 cycles.
`timescale 1ns/1ns
`default_nettype none

module sensor_fifo_status_reset_regs_tb_top;
  import sensor_regs_pkg::*;
  localparam int CFG_P = 20;
  localparam int FULL_P = 50;
  localparam logic [7:0] GAIN = 8'hA5;
  localparam logic [6:0] DELTA = 7'h5B;
  localparam logic [8:0] BASE = 9'h1C3;
  logic clk_in, rst_in, wr_en, rd_en, push, flush, busy, reload, rvalid;
  logic flush_c1, busy_c1, reload_c1;
  logic [7:0] addr, wdata, rdata, cfg, d;
  logic [5:0] level;
  logic [4:0] wm;
  logic [159:0] press;
  int err_count, checks;

  fifo_occupancy_model fifo (.clk_in(clk_in), .rst_in(rst_in), .push_in(push), .flush_in(flush), .level_out(level));

  sensor_fifo_status_reset_regs #(.CONFIG_RESET_CYCLES_P(CFG_P), .FULL_RESET_CYCLES_P(FULL_P)) dut (
    .clk_in(clk_in), .rst_in(rst_in), .reg_addr_in(addr), .reg_write_in(wr_en), .reg_wdata_in(wdata),
    .reg_read_in(rd_en), .reg_rdata_out(rdata), .reg_rvalid_out(rvalid), .fifo_fill_level_in(level),
    .fifo_flush_out(flush), .fifo_config_out(cfg), .watermark_config_out(wm), .soft_reset_busy_out(busy),
    .fuse_temp_gain_in(GAIN), .fuse_temp_delta_in(DELTA), .fuse_temp_base_in(BASE),
    .fuse_press_coeff_in(press), .fuse_reload_out(reload));

  // ****
  // Bus tasks and comparisons
  // ****
  task automatic cmp8(input string name, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask : cmp8

  task automatic cmp_n(input string name, input int exp, input int got);
    checks++;
    if (got != exp)
    begin
      err_count++;
      $display("[ERR] %s expected %0d seen %0d", name, exp, got);
    end
  endtask : cmp_n

  // Strobes are one cycle wide; snapshots taken in the cycle after the write
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(negedge clk_in);
    addr = a;
    wdata = v;
    wr_en = 1'b1;
    @(negedge clk_in);
    wr_en = 1'b0;
    flush_c1 = flush;
    busy_c1 = busy;
    reload_c1 = reload;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    @(negedge clk_in);
    addr = a;
    rd_en = 1'b1;
    @(negedge clk_in);
    rd_en = 1'b0;
    for (int i = 0; (i < 3) && (rvalid !== 1'b1); i++)
      @(negedge clk_in);
    cmp8("read answer", 8'h01, {7'h00, rvalid});
    d = rdata;
  endtask : rd

  task automatic chk(input logic [7:0] a, input logic [7:0] exp, input string name);
    rd(a);
    cmp8(name, exp, d);
  endtask : chk

  // Outside a soft reset flags move only on the refresh tick, so poll a little over one period
  task automatic poll(input logic [7:0] exp, input string name);
    for (int i = 0; i < 1400; i++)
    begin
      rd(ADDR_FIFO_FILL_STATUS);
      if (d === exp)
        break;
    end
    cmp8(name, exp, d);
  endtask : poll

  task automatic push_n(input int n);
    @(negedge clk_in);
    push = 1'b1;
    repeat (n) @(negedge clk_in);
    push = 1'b0;
  endtask : push_n

  // ****
  // Scenarios
  // ****
  task automatic t_ids();
    chk(ADDR_FIFO_FILL_STATUS, 8'h01, "status at reset");
    chk(ADDR_PART_AND_REVISION_ID, {REVISION_CODE, PRODUCT_CODE}, "identity");
    wr(ADDR_PART_AND_REVISION_ID, 8'hFF);
    chk(ADDR_PART_AND_REVISION_ID, {REVISION_CODE, PRODUCT_CODE}, "identity kept");
    chk(ADDR_FLUSH_AND_SOFT_RESET, READ_ZERO, "reset control read");
    chk(8'h3F, 8'h00, "unmapped read");
    chk(ADDR_WATERMARK_CONFIG, {3'h0, WATERMARK_RESET}, "watermark default");
    $display("test ids done");
  endtask : t_ids

  task automatic t_coeff();
    logic [7:0] gain_b, delta_b, base_b;
    // One sweep over the three bytes, then unpack the fields as a host would
    rd(ADDR_TEMP_GAIN_COEFFICIENT);
    gain_b = d;
    rd(ADDR_TEMP_DELTA_COEFFICIENT);
    delta_b = d;
    rd(ADDR_TEMP_BASE_COEFFICIENT);
    base_b = d;
    cmp8("gain", GAIN, gain_b);
    cmp8("delta", {1'b0, DELTA}, {1'b0, delta_b[7:1]});
    cmp8("base high", BASE[8:1], base_b);
    cmp8("base low", {7'h00, BASE[0]}, {7'h00, delta_b[0]});
    wr(ADDR_TEMP_GAIN_COEFFICIENT, ~GAIN);
    chk(ADDR_TEMP_GAIN_COEFFICIENT, GAIN, "gain kept");
    for (int k = 0; k < PRESS_COEFF_BYTES; k++)
      chk(ADDR_PRESS_COEFF_FIRST + 8'(k), 8'(8'h40 + k), "press coeff");
    wr(ADDR_PRESS_COEFF_LAST, 8'h00);
    chk(ADDR_PRESS_COEFF_LAST, 8'h53, "press kept");
    $display("test coeff done");
  endtask : t_coeff

  task automatic t_status();
    wr(ADDR_WATERMARK_CONFIG, 8'h03);
    wr(ADDR_FIFO_CONFIG, {SELECT_WATERMARK, 4'h0});
    cmp8("config port", {SELECT_WATERMARK, 4'h0}, cfg);
    cmp8("watermark port", 8'h03, {3'h0, wm});
    push_n(3);
    rd(ADDR_FIFO_FILL_STATUS);
    cmp8("fill level", 8'h0C, {d[7:2], 2'b00});
    poll(8'h0C, "below threshold");
    repeat (2600) @(negedge clk_in);
    chk(ADDR_FIFO_FILL_STATUS, 8'h0C, "threshold minus one");
    push_n(1);
    poll(8'h12, "threshold reached");
    wr(ADDR_FIFO_CONFIG, {SELECT_FIFO_FULL, 4'h0});
    poll(8'h10, "not yet full");
    push_n(28);
    poll(8'h82, "fifo full");
    $display("test status done");
  endtask : t_status

  task automatic t_flush();
    wr(ADDR_FLUSH_AND_SOFT_RESET, 8'h80);
    cmp8("flush pulse", 8'h01, {7'h00, flush_c1});
    cmp8("busy on flush", 8'h00, {7'h00, busy_c1});
    @(negedge clk_in);
    cmp8("flush released", 8'h00, {7'h00, flush});
    rd(ADDR_FIFO_FILL_STATUS);
    cmp8("level after flush", 8'h00, {d[7:2], 2'b00});
    poll(8'h01, "empty after flush");
    chk(ADDR_FLUSH_AND_SOFT_RESET, READ_ZERO, "reset control read");
    $display("test flush done");
  endtask : t_flush

  task automatic t_soft(input logic [3:0] code, input int len, input logic rl);
    int n;
    wr(ADDR_FIFO_CONFIG, 8'h84);
    wr(ADDR_WATERMARK_CONFIG, 8'h05);
    push_n(5);
    wr(ADDR_FLUSH_AND_SOFT_RESET, {4'h0, code});
    cmp8("busy start", 8'h01, {7'h00, busy_c1});
    cmp8("flush during reset", 8'h01, {7'h00, flush_c1});
    cmp8("fuse reload", {7'h00, rl}, {7'h00, reload_c1});
    wr(ADDR_WATERMARK_CONFIG, 8'h11);
    // Flags are forced one edge after busy rises, so this read sees an empty FIFO
    rd(ADDR_FIFO_FILL_STATUS);
    cmp8("status during reset", 8'h01, d);
    for (n = 5; (busy === 1'b1) && (n < len + 10); n++)
      @(negedge clk_in);
    cmp_n("busy cycles", len, n - 1);
    cmp8("config port", FIFO_CONFIG_RESET, cfg);
    cmp8("watermark port", {3'h0, WATERMARK_RESET}, {3'h0, wm});
    chk(ADDR_FIFO_CONFIG, FIFO_CONFIG_RESET, "config default");
    chk(ADDR_WATERMARK_CONFIG, {3'h0, WATERMARK_RESET}, "write ignored");
    chk(ADDR_FIFO_FILL_STATUS, 8'h01, "empty after reset");
    chk(ADDR_TEMP_DELTA_COEFFICIENT, {DELTA, BASE[0]}, "fuses intact");
    $display("test soft reset %h done", code);
  endtask : t_soft

  task automatic results();
    $display("checks %0d mismatches %0d", checks, err_count);
    if ((err_count == 0) && (checks > 0))
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : results

  // Clock at 10 MHz
  initial
  begin
    clk_in = 1'b0;
    forever #50 clk_in = ~clk_in;
  end

  // Hang guard
  initial
  begin
    repeat (90000) @(posedge clk_in);
    err_count++;
    $display("[ERR] run length expected done seen hung");
    results();
  end

  // Main sequence
  initial
  begin
    err_count = 0;
    checks = 0;
    rst_in = 1'b1;
    wr_en = 1'b0;
    rd_en = 1'b0;
    push = 1'b0;
    addr = 8'h00;
    wdata = 8'h00;
    for (int k = 0; k < PRESS_COEFF_BYTES; k++)
      press[8*k +: 8] = 8'(8'h40 + k);
    repeat (3) @(negedge clk_in);
    rst_in = 1'b0;
    t_ids();
    t_coeff();
    t_status();
    t_flush();
    t_soft(SOFT_RESET_CONFIG, CFG_P, 1'b0);
    t_soft(SOFT_RESET_FULL, FULL_P, 1'b1);
    results();
  end
endmodule : sensor_fifo_status_reset_regs_tb_top

`default_nettype wire

// file: src/sensor_fifo_status_reset_regs.sv
// FIFO status, flush/soft reset, identity and fused coefficient registers of the sensor.
// Assumes the serial front end presents byte reads and writes on the core clock and that
// the FIFO, measurement engine and fuse array sit on the same clock.
`timescale 1ns/1ns
`default_nettype none

// What this block does
// - Status bits 7:2 show how many results the FIFO holds.
// - Status bit 1 flags FIFO full or watermark reached, per selected source.
// - Outside a soft reset, full/threshold and empty flags refresh every 250 us, not instantly.
// - Status bit 0 is one when FIFO empty, zero otherwise.
// - Writing one to reset-control bit 7 flushes every FIFO entry.
// - Code 0b1000 resets configuration, keeps fuses, takes about 0.7 ms.
// - Code 0b1001 is a full reset with fuse reload, about 3 ms.
// - Identity bits 7:4 hold the revision number.
// - Identity bits 3:0 hold a fixed product code.
// - Three temperature coefficients sit read-only at 0x20 to 0x22.
// - Gain at 0x20; delta in 0x21 bits 7:1; base bit0 then 0x22.
// - Pressure coefficients are read-only at 0x26 to 0x39.
// - Watermark threshold is the five-bit code plus one.
// - Select code 0100 picks watermark, 1000 picks FIFO full.
module sensor_fifo_status_reset_regs
  import sensor_regs_pkg::*;
#(
  parameter int CONFIG_RESET_CYCLES_P = CONFIG_RESET_CYCLES,
  parameter int FULL_RESET_CYCLES_P = FULL_RESET_CYCLES
)
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Register port from the serial front end
  input wire logic [7:0] reg_addr_in,
  input wire logic reg_write_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_read_in,
  output logic [7:0] reg_rdata_out,
  output logic reg_rvalid_out,
  // FIFO side
  input wire logic [5:0] fifo_fill_level_in,
  output logic fifo_flush_out,
  // Configuration toward FIFO and interrupt logic
  output logic [7:0] fifo_config_out,
  output logic [4:0] watermark_config_out,
  output logic soft_reset_busy_out,
  // Fuse array
  input wire logic [7:0] fuse_temp_gain_in,
  input wire logic [6:0] fuse_temp_delta_in,
  input wire logic [8:0] fuse_temp_base_in,
  input wire logic [8*PRESS_COEFF_BYTES-1:0] fuse_press_coeff_in,
  output logic fuse_reload_out
);

  // ****************************************
  // State
  // ****************************************
  reset_state_t state;
  reset_state_t next_state;
  logic [TIMER_W-1:0] timer;
  logic [TIMER_W-1:0] next_timer;
  logic [7:0] next_fifo_config;
  logic [4:0] next_watermark;
  logic [7:0] next_rdata;
  logic next_rvalid;
  logic next_flush;
  logic next_busy;
  logic next_reload;
  logic wr_reset_reg;
  logic flag_sampled;
  logic empty_sampled;
  logic [7:0] temp_gain;
  logic [6:0] temp_delta;
  logic [8:0] temp_base;
  logic [7:0] press_coeff [PRESS_COEFF_BYTES];
  logic [7:0] next_press_coeff [PRESS_COEFF_BYTES];
  logic [7:0] next_temp_gain;
  logic [6:0] next_temp_delta;
  logic [8:0] next_temp_base;
  logic [7:0] press_index;

  assign wr_reset_reg = reg_write_in && (reg_addr_in == ADDR_FLUSH_AND_SOFT_RESET) && !soft_reset_busy_out;
  assign press_index = reg_addr_in - ADDR_PRESS_COEFF_FIRST;

  // ****************************************
  // Flag refresh
  // ****************************************
  status_flag_refresh u_flags (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .fill_level_in(fifo_fill_level_in),
    .watermark_level_in(watermark_config_out),
    .source_select_in(fifo_config_out[CFG_SELECT_LSB +: 4]),
    .force_empty_in(soft_reset_busy_out),
    .full_or_threshold_flag_out(flag_sampled),
    .empty_flag_out(empty_sampled)
  );

  // Register writes, read answers and the soft reset sequencer
  always_comb
  begin
    next_state = state;
    next_timer = timer;
    next_fifo_config = fifo_config_out;
    next_watermark = watermark_config_out;
    next_flush = 1'b0;
    next_reload = 1'b0;
    next_rvalid = reg_read_in;
    next_rdata = READ_ZERO;
    case (state)
      ST_IDLE:
      begin
        next_timer = '0;
        if (reg_write_in && (reg_addr_in == ADDR_FIFO_CONFIG))
          next_fifo_config = reg_wdata_in;
        if (reg_write_in && (reg_addr_in == ADDR_WATERMARK_CONFIG))
          next_watermark = reg_wdata_in[4:0];
        if (wr_reset_reg)
        begin
          next_flush = reg_wdata_in[RST_FLUSH_BIT];
          // Other codes are left alone; the host is trusted to use only the two defined ones
          if (reg_wdata_in[3:0] == SOFT_RESET_CONFIG)
          begin
            next_state = ST_CONFIG_RESET;
            next_fifo_config = FIFO_CONFIG_RESET;
            next_watermark = WATERMARK_RESET;
            next_flush = 1'b1;
          end
          else if (reg_wdata_in[3:0] == SOFT_RESET_FULL)
          begin
            next_state = ST_FULL_RESET;
            next_fifo_config = FIFO_CONFIG_RESET;
            next_watermark = WATERMARK_RESET;
            next_flush = 1'b1;
            next_reload = 1'b1;
          end
        end
      end
      ST_CONFIG_RESET:
      begin
        // Writes are dropped here; the FIFO is held flushed until the end
        next_flush = 1'b1;
        next_timer = timer + 1'b1;
        if (timer == TIMER_W'(CONFIG_RESET_CYCLES_P - 1))
          next_state = ST_IDLE;
      end
      ST_FULL_RESET:
      begin
        next_flush = 1'b1;
        next_timer = timer + 1'b1;
        if (timer == TIMER_W'(FULL_RESET_CYCLES_P - 1))
          next_state = ST_IDLE;
      end
      default:
      begin
        next_state = ST_IDLE;
      end
    endcase
    next_busy = (next_state != ST_IDLE);
    // Read decode; unmapped and write-only addresses answer zero
    if (reg_read_in)
    begin
      if (reg_addr_in == ADDR_FIFO_CONFIG)
        next_rdata = fifo_config_out;
      else if (reg_addr_in == ADDR_WATERMARK_CONFIG)
        next_rdata = {3'b000, watermark_config_out};
      else if (reg_addr_in == ADDR_FIFO_FILL_STATUS)
      begin
        next_rdata[7:STS_LEVEL_LSB] = soft_reset_busy_out ? 6'h00 : fifo_fill_level_in;
        next_rdata[STS_FLAG_BIT] = flag_sampled;
        next_rdata[STS_EMPTY_BIT] = empty_sampled;
      end
      else if (reg_addr_in == ADDR_FLUSH_AND_SOFT_RESET)
        next_rdata = READ_ZERO;
      else if (reg_addr_in == ADDR_PART_AND_REVISION_ID)
        next_rdata = {REVISION_CODE, PRODUCT_CODE};
      else if (reg_addr_in == ADDR_TEMP_GAIN_COEFFICIENT)
        next_rdata = temp_gain;
      else if (reg_addr_in == ADDR_TEMP_DELTA_COEFFICIENT)
        next_rdata = {temp_delta, temp_base[0]};
      else if (reg_addr_in == ADDR_TEMP_BASE_COEFFICIENT)
        next_rdata = temp_base[8:1];
      else if ((reg_addr_in >= ADDR_PRESS_COEFF_FIRST) && (reg_addr_in <= ADDR_PRESS_COEFF_LAST))
        next_rdata = press_coeff[press_index[4:0]];
    end
  end

  // Control registers; outside a soft reset the flush output is a one-cycle pulse, so the control register keeps nothing
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      state <= ST_IDLE;
      timer <= '0;
      fifo_config_out <= FIFO_CONFIG_RESET;
      watermark_config_out <= WATERMARK_RESET;
      reg_rdata_out <= READ_ZERO;
      reg_rvalid_out <= 1'b0;
      fifo_flush_out <= 1'b0;
      soft_reset_busy_out <= 1'b0;
      fuse_reload_out <= 1'b1;
    end
    else
    begin
      state <= next_state;
      timer <= next_timer;
      fifo_config_out <= next_fifo_config;
      watermark_config_out <= next_watermark;
      reg_rdata_out <= next_rdata;
      reg_rvalid_out <= next_rvalid;
      fifo_flush_out <= next_flush;
      soft_reset_busy_out <= next_busy;
      fuse_reload_out <= next_reload;
    end
  end

  // ****************************************
  // Fused coefficient shadows
  // ****************************************
  // Loaded once after power-on and again on a full reset; a config reset leaves them alone
  always_comb
  begin
    next_temp_gain = temp_gain;
    next_temp_delta = temp_delta;
    next_temp_base = temp_base;
    if (fuse_reload_out)
    begin
      next_temp_gain = fuse_temp_gain_in;
      next_temp_delta = fuse_temp_delta_in;
      next_temp_base = fuse_temp_base_in;
    end
  end

  // Temperature shadow registers
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      temp_gain <= 8'h00;
      temp_delta <= 7'h00;
      temp_base <= 9'h000;
    end
    else
    begin
      temp_gain <= next_temp_gain;
      temp_delta <= next_temp_delta;
      temp_base <= next_temp_base;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < PRESS_COEFF_BYTES; gi++)
    begin : g_press
      assign next_press_coeff[gi] = fuse_reload_out ? fuse_press_coeff_in[8*gi +: 8] : press_coeff[gi];
      always_ff @(posedge clk_in or posedge rst_in)
      begin
        if (rst_in)
          press_coeff[gi] <= 8'h00;
        else
          press_coeff[gi] <= next_press_coeff[gi];
      end
    end
  endgenerate

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (rst_in);

  sequence s_config_reset_req;
    wr_reset_reg && (reg_wdata_in[3:0] == SOFT_RESET_CONFIG);
  endsequence

  sequence s_full_reset_req;
    wr_reset_reg && (reg_wdata_in[3:0] == SOFT_RESET_FULL);
  endsequence

  // The forced flags land one edge after busy rises, so only later reads are judged
  sequence s_status_read_in_reset;
    soft_reset_busy_out ##1 (soft_reset_busy_out && reg_read_in && (reg_addr_in == ADDR_FIFO_FILL_STATUS));
  endsequence

  a_flush_on_write: assert property (
    wr_reset_reg && reg_wdata_in[RST_FLUSH_BIT] |=> fifo_flush_out) else $error("flush not issued");
  a_config_reset_go: assert property (
    s_config_reset_req |=> soft_reset_busy_out && (watermark_config_out == WATERMARK_RESET) && !fuse_reload_out)
    else $error("config reset did not start");
  a_full_reset_go: assert property (
    s_full_reset_req |=> soft_reset_busy_out && fuse_reload_out ##1 (temp_gain == $past(fuse_temp_gain_in)))
    else $error("full reset did not reload fuses");
  a_busy_drops_write: assert property (
    soft_reset_busy_out && reg_write_in |=> $stable(watermark_config_out) && $stable(fifo_config_out))
    else $error("write taken during soft reset");
  a_reset_reg_zero: assert property (
    reg_read_in && (reg_addr_in == ADDR_FLUSH_AND_SOFT_RESET) |=> reg_rvalid_out && (reg_rdata_out == 8'h00))
    else $error("reset control read not zero");
  a_id_readback: assert property (
    reg_read_in && (reg_addr_in == ADDR_PART_AND_REVISION_ID) |=> reg_rdata_out == {REVISION_CODE, PRODUCT_CODE})
    else $error("identity byte wrong");
  a_delta_packing: assert property (
    reg_read_in && (reg_addr_in == ADDR_TEMP_DELTA_COEFFICIENT) && !fuse_reload_out
    |=> reg_rdata_out == {temp_delta, temp_base[0]}) else $error("delta coefficient packing wrong");
  a_level_readback: assert property (
    reg_read_in && (reg_addr_in == ADDR_FIFO_FILL_STATUS) && !soft_reset_busy_out
    |=> reg_rdata_out[7:2] == $past(fifo_fill_level_in)) else $error("fill level wrong");
  a_flush_held_busy: assert property (
    soft_reset_busy_out ##1 soft_reset_busy_out |-> fifo_flush_out) else $error("FIFO not held flushed");
  a_status_in_reset: assert property (
    s_status_read_in_reset |=> reg_rdata_out == 8'h01)
    else $error("status not empty during soft reset");
  a_reload_pulse: assert property (
    fuse_reload_out |=> !fuse_reload_out) else $error("fuse reload longer than one cycle");
  a_fuse_hold: assert property (
    !fuse_reload_out |=> $stable(temp_gain) && $stable(temp_delta) && $stable(temp_base))
    else $error("fuse shadow moved without reload");

endmodule : sensor_fifo_status_reset_regs

`default_nettype wire

// file: src/sensor_regs_pkg.sv
// Constants shared by the FIFO status, reset control, identity and coefficient registers.
// Assumes a single 10 MHz core clock and a byte-wide internal register port behind the serial front end.
package sensor_regs_pkg;

  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [7:0] ADDR_FIFO_CONFIG = 8'h09;
  localparam logic [7:0] ADDR_WATERMARK_CONFIG = 8'h0B;
  localparam logic [7:0] ADDR_FIFO_FILL_STATUS = 8'h0C;
  localparam logic [7:0] ADDR_FLUSH_AND_SOFT_RESET = 8'h0D;
  localparam logic [7:0] ADDR_PART_AND_REVISION_ID = 8'h1D;
  localparam logic [7:0] ADDR_TEMP_GAIN_COEFFICIENT = 8'h20;
  localparam logic [7:0] ADDR_TEMP_DELTA_COEFFICIENT = 8'h21;
  localparam logic [7:0] ADDR_TEMP_BASE_COEFFICIENT = 8'h22;
  localparam logic [7:0] ADDR_PRESS_COEFF_FIRST = 8'h26;
  localparam logic [7:0] ADDR_PRESS_COEFF_LAST = 8'h39;
  localparam int PRESS_COEFF_BYTES = 20;

  // ****************************************
  // Field positions and codes
  // ****************************************
  localparam int STS_LEVEL_LSB = 2;
  localparam int STS_FLAG_BIT = 1;
  localparam int STS_EMPTY_BIT = 0;
  localparam int RST_FLUSH_BIT = 7;
  localparam int CFG_SELECT_LSB = 4;
  localparam logic [3:0] SOFT_RESET_CONFIG = 4'h8;
  localparam logic [3:0] SOFT_RESET_FULL = 4'h9;
  localparam logic [3:0] SELECT_WATERMARK = 4'h4;
  localparam logic [3:0] SELECT_FIFO_FULL = 4'h8;
  localparam logic [5:0] FIFO_DEPTH = 6'h20;

  // ****************************************
  // Reset values and identity
  // ****************************************
  localparam logic [4:0] WATERMARK_RESET = 5'h1F;
  localparam logic [7:0] FIFO_CONFIG_RESET = 8'h00;
  localparam logic [7:0] READ_ZERO = 8'h00;
  localparam logic [3:0] PRODUCT_CODE = 4'h5; // Arbitrary value
  localparam logic [3:0] REVISION_CODE = 4'h1; // Arbitrary value

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 100;
  localparam int REFRESH_NS = 250000;
  localparam int CONFIG_RESET_NS = 700000;
  localparam int FULL_RESET_NS = 3000000;
  localparam int REFRESH_CYCLES = REFRESH_NS / CLK_PERIOD_NS;
  localparam int CONFIG_RESET_CYCLES = (CONFIG_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FULL_RESET_CYCLES = (FULL_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int REFRESH_W = 12;
  localparam int TIMER_W = 15;

  // Soft reset sequencer states
  typedef enum logic [1:0] {ST_IDLE, ST_CONFIG_RESET, ST_FULL_RESET} reset_state_t;

endpackage : sensor_regs_pkg

// file: src/status_flag_refresh.sv
// Periodic sampler for the full/threshold flag and the empty flag of the FIFO status byte.
// Assumes fill level and configuration arrive from logic on the same clock.
`timescale 1ns/1ns
`default_nettype none

module status_flag_refresh
  import sensor_regs_pkg::*;
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Live FIFO state and configuration
  input wire logic [5:0] fill_level_in,
  input wire logic [4:0] watermark_level_in,
  input wire logic [3:0] source_select_in,
  input wire logic force_empty_in,
  // Sampled flags
  output logic full_or_threshold_flag_out,
  output logic empty_flag_out
);

  logic [REFRESH_W-1:0] tick_count;
  logic [REFRESH_W-1:0] next_tick_count;
  logic next_flag;
  logic next_empty;
  logic live_flag;

  // Flags move only on the refresh tick or a forced empty, so a read can lag the FIFO by one period
  always_comb
  begin
    live_flag = 1'b0;
    if (source_select_in == SELECT_WATERMARK)
      live_flag = ({1'b0, fill_level_in} >= ({2'b00, watermark_level_in} + 7'h01));
    else if (source_select_in == SELECT_FIFO_FULL)
      live_flag = (fill_level_in >= FIFO_DEPTH);
    next_tick_count = tick_count + 1'b1;
    next_flag = full_or_threshold_flag_out;
    next_empty = empty_flag_out;
    if (tick_count == REFRESH_W'(REFRESH_CYCLES - 1))
    begin
      next_tick_count = '0;
      next_flag = live_flag;
      next_empty = (fill_level_in == 6'h00);
    end
    // A soft reset shows an empty FIFO at once rather than a period later
    if (force_empty_in)
    begin
      next_flag = 1'b0;
      next_empty = 1'b1;
    end
  end

  // Tick counter and flag registers
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      tick_count <= '0;
      full_or_threshold_flag_out <= 1'b0;
      empty_flag_out <= 1'b1;
    end
    else
    begin
      tick_count <= next_tick_count;
      full_or_threshold_flag_out <= next_flag;
      empty_flag_out <= next_empty;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  a_refresh_period: assert property (@(posedge clk_in) disable iff (rst_in)
    tick_count < REFRESH_W'(REFRESH_CYCLES)) else $error("refresh counter beyond period");
  a_flags_hold: assert property (@(posedge clk_in) disable iff (rst_in)
    (tick_count != REFRESH_W'(REFRESH_CYCLES - 1)) && !force_empty_in |=> $stable(empty_flag_out))
    else $error("empty flag moved between ticks");
  a_empty_sample: assert property (@(posedge clk_in) disable iff (rst_in)
    (tick_count == REFRESH_W'(REFRESH_CYCLES - 1)) && !force_empty_in
    |=> empty_flag_out == ($past(fill_level_in) == 6'h00)) else $error("empty flag wrong at tick");
  a_full_sample: assert property (@(posedge clk_in) disable iff (rst_in)
    (tick_count == REFRESH_W'(REFRESH_CYCLES - 1)) && !force_empty_in && (source_select_in == SELECT_FIFO_FULL)
    |=> full_or_threshold_flag_out == ($past(fill_level_in) == FIFO_DEPTH))
    else $error("full flag wrong at tick");
  a_threshold_sample: assert property (@(posedge clk_in) disable iff (rst_in)
    (tick_count == REFRESH_W'(REFRESH_CYCLES - 1)) && !force_empty_in && (source_select_in == SELECT_WATERMARK)
    |=> full_or_threshold_flag_out == ($past(fill_level_in) > {1'b0, $past(watermark_level_in)}))
    else $error("threshold flag wrong at tick");

endmodule : status_flag_refresh

`default_nettype wire
